/* File: hdl/pmr_regs.v */
// Power-management capability registers of a bridge, AHB-Lite slave.
// ============================================================
// How it works
// - Capability bits 18:16 always read 010, revision 1.1.
// - Capability bits 19, 20 and 31:27 always read zero.
// - Capability bit 21 reads zero; no special initialisation.
// - Capability bit 25 reads one: D1 supported.
// - Capability bit 26 reads one: D2 supported.
// - Power state bits 1:0 hold D0..D3, clearing to D0 on reset.
// - Unsupported state written: write completes, field unchanged.
// - D0 written after D3 pulses chip reset, not secondary reset.
// - Control bits 8 and 15 are read-only zero.
// - Control bits 12:9 and 14:13 are read-only zero.
// - Strap high: bit 22 reads one, secondary clocks stop in D3.
// - Bit 23 mirrors the strap; strap low keeps clocks running.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pmr_defs.vh"

module pmr_regs #(
    parameter CHIP_RST_CYCLES = 4
) (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        sys_rst,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg  [31:0] hrdata,
    output reg         hresp,
    // Strap and bridge controls
    input  wire        clock_control_strap,
    output reg  [1:0]  power_state,
    output reg         chip_reset,
    output reg         sec_bus_reset,
    output reg         sec_clk_stop
);

    // ============================================================
    // Helpers
    function state_ok;
        input [1:0] st;
        reg   [3:0] sup;
        begin
            sup = `PMR_STATE_SUPPORT;
            state_ok = sup[st];
        end
    endfunction

    // ============================================================
    // Address phase capture
    reg        dp_write;
    reg [7:0]  dp_addr;
    reg [2:0]  dp_size;
    reg        strap;
    reg [7:0]  rst_cnt;
    wire       valid_req;
    wire       csr_wr;
    reg  [1:0] next_state;
    reg [31:0] rd_word;

    assign valid_req = hsel && hready &&
                       (htrans == `PMR_HTRANS_NONSEQ ||
                        htrans == `PMR_HTRANS_SEQ);

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
            dp_size  <= `PMR_HSIZE_WORD;
        end else if (hready) begin
            dp_write <= valid_req && hwrite;
            dp_addr  <= haddr;
            dp_size  <= hsize;
        end
    end

    // Only a write that covers byte lane 0 reaches the state field.
    assign csr_wr = dp_write &&
                    dp_addr[7:2] == `PMR_IDX_CSR &&
                    (dp_size == `PMR_HSIZE_WORD ||
                     dp_addr[1:0] == 2'b00);

    // ============================================================
    // Power state
    always @* begin
        next_state = power_state;
        if (csr_wr && state_ok(hwdata[`PMR_PS_HI:`PMR_PS_LO])) begin
            next_state = hwdata[`PMR_PS_HI:`PMR_PS_LO];
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            power_state <= `PMR_PS_RESET;
        end else begin
            power_state <= next_state;
        end
    end

    // The strap is sampled during reset and frozen at its release.
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            strap <= clock_control_strap;
        end
    end

    // ============================================================
    // Chip reset and clock control
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            rst_cnt    <= 8'h00;
            chip_reset <= 1'b0;
        end else begin
            if (power_state == `PMR_D3 && next_state == `PMR_D0) begin
                rst_cnt <= CHIP_RST_CYCLES[7:0];
            end else if (rst_cnt != 8'h00) begin
                rst_cnt <= rst_cnt - 8'h01;
            end
            chip_reset <= (power_state == `PMR_D3 &&
                           next_state == `PMR_D0) ||
                          rst_cnt > 8'h01;
        end
    end

    // Secondary reset follows only the bridge reset, never chip reset.
    always @(posedge sys_clk) begin
        sec_bus_reset <= sys_rst;
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            sec_clk_stop <= 1'b0;
        end else begin
            sec_clk_stop <= strap && next_state == `PMR_D3;
        end
    end

    // ============================================================
    // Read mux
    // The mux reads next_state so a read right after a write sees it.
    always @* begin
        rd_word = `PMR_ZERO32;
        if (haddr[7:2] == `PMR_IDX_CAP) begin
            rd_word[7:0]  = `PMR_CAP_ID;
            rd_word[15:8] = `PMR_NEXT_PTR;
            rd_word[`PMR_REV_HI:`PMR_REV_LO] = `PMR_PM_REV;
            rd_word[`PMR_WAKE_CLK_BIT] = 1'b0;
            rd_word[`PMR_AUX_PWR_BIT]  = 1'b0;
            rd_word[`PMR_WAKE_SUP_HI:`PMR_WAKE_SUP_LO] = 5'b00000;
            rd_word[`PMR_DSI_BIT] = 1'b0;
            rd_word[`PMR_D1_BIT] = 1'b1;
            rd_word[`PMR_D2_BIT] = 1'b1;
        end else if (haddr[7:2] == `PMR_IDX_CSR) begin
            rd_word[`PMR_PS_HI:`PMR_PS_LO] = next_state;
            rd_word[`PMR_WAKE_EN_BIT]  = 1'b0;
            rd_word[`PMR_WAKE_STS_BIT] = 1'b0;
            rd_word[`PMR_DSEL_HI:`PMR_DSEL_LO] = 4'h0;
            rd_word[`PMR_DSCALE_HI:`PMR_DSCALE_LO] = 2'b00;
            rd_word[`PMR_CLK_STOP_BIT] = strap;
            rd_word[`PMR_STRAP_BIT] = strap;
        end
    end

    // ============================================================
    // Bus response
    // Zero wait states, so the slave never stretches a transfer.
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= `PMR_ZERO32;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (valid_req && !hwrite) begin
                hrdata <= rd_word;
            end
        end
    end

endmodule
`default_nettype wire

/* File: hdl/pmr_defs.vh */
// Constants of the bridge power-management register bank.
`ifndef PMR_DEFS_VH
`define PMR_DEFS_VH
// ============================================================
// Register byte addresses
`define PMR_ADDR_CAP       8'hdc
`define PMR_ADDR_CSR       8'he0
// Word indices, the byte addresses above divided by four.
`define PMR_IDX_CAP        6'h37
`define PMR_IDX_CSR        6'h38
// ============================================================
// Fixed capability fields
`define PMR_CAP_ID         8'h01
`define PMR_NEXT_PTR       8'h00
`define PMR_PM_REV         3'b010
// ============================================================
// Field positions
`define PMR_REV_LO         16
`define PMR_REV_HI         18
`define PMR_WAKE_CLK_BIT   19
`define PMR_AUX_PWR_BIT    20
`define PMR_DSI_BIT        21
`define PMR_D1_BIT         25
`define PMR_D2_BIT         26
`define PMR_WAKE_SUP_LO    27
`define PMR_WAKE_SUP_HI    31
`define PMR_PS_LO          0
`define PMR_PS_HI          1
`define PMR_WAKE_EN_BIT    8
`define PMR_DSEL_LO        9
`define PMR_DSEL_HI        12
`define PMR_DSCALE_LO      13
`define PMR_DSCALE_HI      14
`define PMR_WAKE_STS_BIT   15
`define PMR_CLK_STOP_BIT   22
`define PMR_STRAP_BIT      23
// ============================================================
// Power states and reset values
`define PMR_D0             2'b00
`define PMR_D1             2'b01
`define PMR_D2             2'b10
`define PMR_D3             2'b11
`define PMR_PS_RESET       2'b00
`define PMR_STATE_SUPPORT  4'b1111
// ============================================================
// AHB-Lite encodings
`define PMR_HTRANS_NONSEQ  2'b10
`define PMR_HTRANS_SEQ     2'b11
`define PMR_HSIZE_WORD     3'b010
`define PMR_ZERO32         32'h0000_0000
`endif

/* File: tb/pmr_props.sv */
// Assertion checker for the power register bank.
`timescale 1ns/1ps
`default_nettype none
module pmr_props #(parameter CHIP_RST_CYCLES = 4) (
    input wire logic        sys_clk, sys_rst, hsel, hwrite, hreadyout,
    input wire logic        hresp, clock_control_strap, chip_reset,
    input wire logic        sec_bus_reset, sec_clk_stop,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans, power_state,
    input wire logic [31:0] hwdata, hrdata
);
    logic       wph, strap_q;
    logic [7:0] cr_cnt;
    // The strap is latched only in reset, so keep our own copy.
    always @(posedge sys_clk) begin
        if (sys_rst)
            strap_q <= clock_control_strap;
        wph <= !sys_rst && hsel && htrans[1] && hwrite && haddr[7:2] == 6'h38;
        cr_cnt <= chip_reset ? cr_cnt + 8'h01 : 8'h00;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_rd(a); hsel && htrans[1] && !hwrite && haddr[7:2] == a; endsequence
    sequence s_wake; wph && power_state == 2'h3 && hwdata[1:0] == 2'h0; endsequence
    property p_rev; s_rd(6'h37) |=> hrdata[18:16] == 3'h2; endproperty
    a_rev: assert property (p_rev) else $error("bad rev");
    property p_capz; s_rd(6'h37) |=> hrdata[31:27] == 0 && hrdata[21:19] == 0;
    endproperty
    a_capz: assert property (p_capz) else $error("bad cap zeros");
    property p_dsup; s_rd(6'h37) |=> hrdata[26:25] == 2'h3; endproperty
    a_dsup: assert property (p_dsup) else $error("bad d1 d2");
    property p_csrz; s_rd(6'h38) |=> hrdata[15:2] == 14'h0; endproperty
    a_csrz: assert property (p_csrz) else $error("bad csr zeros");
    property p_ext; s_rd(6'h38) |=> hrdata[23:22] == {2{strap_q}}; endproperty
    a_ext: assert property (p_ext) else $error("bad ext bits");
    property p_ps; wph |=> power_state == $past(hwdata[1:0]); endproperty
    a_ps: assert property (p_ps) else $error("bad state");
    property p_stop; wph && hwdata[1:0] == 2'h3 |=> sec_clk_stop == strap_q;
    endproperty
    a_stop: assert property (p_stop) else $error("bad clk stop");
    property p_wake; s_wake |=> chip_reset && !sec_bus_reset && !sec_clk_stop;
    endproperty
    a_wake: assert property (p_wake) else $error("bad wake");
    property p_crlen; $fell(chip_reset) |-> cr_cnt == CHIP_RST_CYCLES; endproperty
    a_crlen: assert property (p_crlen) else $error("bad reset len");
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bad response");
endmodule
bind pmr_regs pmr_props #(.CHIP_RST_CYCLES(CHIP_RST_CYCLES)) pmr_props_i (
    .sys_clk, .sys_rst, .hsel, .hwrite, .hreadyout, .hresp, .chip_reset,
    .clock_control_strap, .sec_bus_reset, .sec_clk_stop, .haddr, .htrans,
    .power_state, .hwdata, .hrdata);
`default_nettype wire

/* File: tb/pmr_host.sv */
// Host model issuing single word transfers.
`timescale 1ns/1ps
`default_nettype none
module pmr_host (
    input  wire logic        sys_clk, hready,
    input  wire logic [31:0] hrdata,
    output var  logic        hsel, hwrite,
    output var  logic [7:0]  haddr,
    output var  logic [1:0]  htrans,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata
);
    initial begin
        {hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
    end
    // No fixed latency is assumed; only the bench watchdog ends a wait.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hready !== 1'h1);
        q = hrdata;
        hwdata <= ~d;
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the power register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        sys_clk, sys_rst, strap, hsel, hwrite, hready, hresp;
    logic        chip_reset, sec_bus_reset, sec_clk_stop;
    logic [7:0]  haddr;
    logic [1:0]  htrans, power_state;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, q;
    int          err_count = 0, cmp_count = 0;
    pmr_regs #(.CHIP_RST_CYCLES(4)) pmr_regs_i (.sys_clk, .sys_rst, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout(hready),
        .hrdata, .hresp, .clock_control_strap(strap), .power_state,
        .chip_reset, .sec_bus_reset, .sec_clk_stop);
    pmr_host pmr_host_i (.sys_clk, .hready, .hrdata, .hsel, .hwrite, .haddr,
        .htrans, .hsize, .hwdata);
    initial begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] g, e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        pmr_host_i.xfer(1'h0, a, 32'h0000_0000, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        pmr_host_i.xfer(1'h1, a, d, q);
    endtask
    // The strap is only seen in reset, so each strap level needs a reset.
    task automatic rst(input logic s);
        sys_rst <= 1'h1;
        strap <= s;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #1000000;
        err_count++;
        results;
    end
    initial begin
        sys_rst = 1'h1;
        strap = 1'h0;
        @(posedge sys_clk);
        rst(1'h0);
        rd(8'hdc, 32'h0602_0001);
        wr(8'hdc, 32'hffff_ffff);
        rd(8'hdc, 32'h0602_0001);
        rd(8'he0, 32'h0000_0000);
        for (int s = 1; s < 4; s++) begin
            wr(8'he0, 32'hffff_fffc | s);
            rd(8'he0, 32'(s));
        end
        chk(sec_clk_stop, 1'h0);
        wr(8'he0, 32'h0000_0000);
        @(posedge sys_clk);
        chk({sec_bus_reset, chip_reset, power_state}, 4'h4);
        rd(8'h40, 32'h0000_0000);
        $display("test 1 done");
        rst(1'h1);
        rd(8'he0, 32'h00c0_0000);
        wr(8'he0, 32'h0000_0003);
        @(posedge sys_clk);
        chk({sec_clk_stop, power_state}, 3'h7);
        wr(8'he0, 32'h0000_0000);
        @(posedge sys_clk);
        chk({sec_clk_stop, chip_reset}, 2'h1);
        rd(8'he0, 32'h00c0_0000);
        $display("test 2 done");
        results;
    end
endmodule
`default_nettype wire
